/* core/clkctl_pkg.sv */
// Purpose: shared constants for the clock controller
// Assumes: 50 MHz clock, plain register port with one-cycle read latency
// Notes:   offsets are word addresses of the plain register port
package clkctl_pkg;
  localparam int unsigned CLK_HZ            = 50_000_000;
  localparam int unsigned CLK_PERIOD_NS     = 20;
  // interval clock periods, in ns
  localparam int unsigned FAST_PERIOD_NS    = 3200;
  localparam int unsigned SLOW_PERIOD_NS    = 102400;
  localparam int unsigned FAST_DIV          = FAST_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned SLOW_DIV          = SLOW_PERIOD_NS / CLK_PERIOD_NS;
  // watchdog timeout, in ms
  localparam int unsigned WDOG_TIMEOUT_MS   = 50;
  localparam int unsigned WDOG_CYCLES       = WDOG_TIMEOUT_MS * (CLK_HZ / 1000);

  // register offsets
  localparam logic [3:0] OFS_CTRL     = 4'h0;
  localparam logic [3:0] OFS_STATUS   = 4'h1;
  localparam logic [3:0] OFS_MASK     = 4'h2;
  localparam logic [3:0] OFS_PRESET   = 4'h3;
  localparam logic [3:0] OFS_COUNT    = 4'h4;
  localparam logic [3:0] OFS_CELLADR  = 4'h5;
  localparam logic [3:0] OFS_VECTOR   = 4'h6;
  localparam logic [3:0] OFS_WDOG     = 4'h7;
  localparam logic [3:0] OFS_ACK      = 4'h8;
  localparam logic [3:0] OFS_PENDING  = 4'h9;

  // control fields
  localparam int unsigned CTRL_IC_RUN     = 0;
  localparam int unsigned CTRL_IC_SLOW    = 1;
  localparam int unsigned CTRL_IC_IRQ     = 2;
  localparam int unsigned CTRL_IC_TICK    = 3;
  localparam int unsigned CTRL_LT_SRC_LO  = 4;
  localparam int unsigned CTRL_LT_RUN     = 6;
  localparam int unsigned CTRL_WD_INT     = 7;
  localparam int unsigned CTRL_WD_RST     = 8;
  localparam int unsigned CTRL_VECTORED   = 9;
  localparam int unsigned CTRL_W          = 10;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;

  // status / mask fields
  localparam int unsigned ST_LT_WRAP = 0;
  localparam int unsigned ST_IC_WRAP = 1;
  localparam int unsigned ST_WD_TO   = 2;
  localparam int unsigned ST_W       = 3;

  localparam logic [15:0] VECTOR_RESET  = 16'h0000;
  localparam logic [15:0] WDOG_INT_LOC  = 16'h0030;
  localparam logic [1:0]  SRC_LINE      = 2'h0;
  localparam logic [1:0]  SRC_EXT       = 2'h1;
  localparam logic [1:0]  SRC_INTERVAL  = 2'h2;

  typedef enum logic [1:0] {
    CLKCTL_IDLE  = 2'b00,
    CLKCTL_READ  = 2'b01,
    CLKCTL_WRITE = 2'b10
  } clkctl_mem_t;
endpackage

/* core/clkctl_prescale.sv */
// Purpose: interval clock period strobe generator
// Assumes: divisors of at least two
// Notes:   restarts from zero when stopped
`timescale 1ns/1ns
`default_nettype none
module clkctl_prescale
  import clkctl_pkg::*;
#(
  parameter int unsigned FAST = FAST_DIV,
  parameter int unsigned SLOW = SLOW_DIV
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // control
  input  wire logic run,
  input  wire logic slow,
  // one-cycle strobe per period
  output logic      period_pulse
);
  localparam int unsigned W = $clog2(SLOW);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] limit;

  assign limit = slow ? W'(SLOW - 1) : W'(FAST - 1);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= '0;
    end else if (!run || cnt_reg >= limit) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + W'(1);
    end
  end

  assign period_pulse = run && (cnt_reg >= limit);
endmodule
`default_nettype wire

/* core/clkctl_sync.sv */
// Purpose: two-flop synchroniser with rising-edge pulse
// Assumes: asynchronous input level
// Notes:   first flop feeds only the second
`timescale 1ns/1ns
`default_nettype none
module clkctl_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // level in, pulse out
  input  wire logic async_in,
  output logic      rise_pulse
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign rise_pulse = sync_reg & ~last_reg;
endmodule
`default_nettype wire

/* core/clkctl_top.sv */
// Purpose: line tick counter, interval clock and program watchdog
// Assumes: host memory port completes each access with mem_done
// Notes:   interval counter counts up from preset and reloads the preset after 0xffff
//
// Summary of operation
// - tick source bumps the chosen memory cell
// - cell wrap to zero raises interrupt, vectored only if selected
// - program picks the memory cell address
// - interval counter steps at 3.2 or 102.4 us
// - preset loadable, counter readable any time
// - interval wrap interrupts, ticks counter, or both
// - interval spans 1 to 65536 periods
// - trigger starts and restarts 50 ms cycle
// - expiry raises external timeout signal
// - expiry optionally resets and interrupts at '60
// - timeout turns isolated output off
// - standard or vectored interrupts, programmable vector
// - pending interrupt blocks others until acknowledged
// - blocks independent, programmed i/o control
`timescale 1ns/1ns
`default_nettype none
module clkctl_top
  import clkctl_pkg::*;
#(
  parameter int unsigned WD_CYCLES = WDOG_CYCLES,
  parameter int unsigned FAST      = FAST_DIV,
  parameter int unsigned SLOW      = SLOW_DIV
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  // memory increment port
  output logic             mem_req,
  output logic             mem_we,
  output logic [15:0]      mem_addr,
  output logic [15:0]      mem_wdata,
  input  wire logic [15:0] mem_rdata,
  input  wire logic        mem_done,
  // interrupts
  output logic             irq,
  output logic             irq_vectored,
  output logic [15:0]      irq_vector,
  output logic             wdog_int,
  output logic             sys_reset,
  // external pins
  input  wire logic        line_freq_in,
  input  wire logic        ext_clk_in,
  output logic             timeout_conduct
);
  localparam int unsigned WDW = $clog2(WD_CYCLES + 1);

  logic [CTRL_W-1:0] ctrl_reg;
  logic [ST_W-1:0]   status_reg;
  logic [ST_W-1:0]   mask_reg;
  logic [15:0]       preset_reg;
  logic [15:0]       count_reg;
  logic [15:0]       cell_reg;
  logic [15:0]       vector_reg;
  logic [WDW-1:0]    wd_cnt_reg;
  logic              wd_run_reg;
  logic              wd_to_reg;
  logic              pend_reg;
  logic              held_reg;
  clkctl_mem_t       mem_state_reg;
  logic [15:0]       rdata_reg;
  logic              line_pulse;
  logic              ext_pulse;
  logic              period_pulse;
  logic              ic_wrap;
  logic              lt_tick;
  logic              lt_wrap;
  logic              wd_trig;
  logic              wd_expire;
  logic [ST_W-1:0]   events;
  logic [ST_W-1:0]   w1c;

  // pin inputs pass two flops first
  clkctl_sync u_line (
    .clk        (clk),
    .rstn       (rstn),
    .async_in   (line_freq_in),
    .rise_pulse (line_pulse)
  );
  clkctl_sync u_ext (
    .clk        (clk),
    .rstn       (rstn),
    .async_in   (ext_clk_in),
    .rise_pulse (ext_pulse)
  );
  clkctl_prescale #(.FAST(FAST), .SLOW(SLOW)) u_pre (
    .clk          (clk),
    .rstn         (rstn),
    .run          (ctrl_reg[CTRL_IC_RUN]),
    .slow         (ctrl_reg[CTRL_IC_SLOW]),
    .period_pulse (period_pulse)
  );

  // control registers written by programmed i/o
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg   <= CTRL_RESET;
      mask_reg   <= '0;
      preset_reg <= 16'h0000;
      cell_reg   <= 16'h0000;
      vector_reg <= VECTOR_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_CTRL:    ctrl_reg   <= reg_wdata[CTRL_W-1:0];
        OFS_MASK:    mask_reg   <= reg_wdata[ST_W-1:0];
        OFS_PRESET:  preset_reg <= reg_wdata;
        OFS_CELLADR: cell_reg   <= reg_wdata;
        OFS_VECTOR:  vector_reg <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // interval counter counts up from preset; 0xffff gives 1 period, 0 gives 65536
  assign ic_wrap = period_pulse && (count_reg == 16'hffff);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= 16'h0000;
    end else if (reg_wr && reg_addr == OFS_PRESET) begin
      count_reg <= reg_wdata;
    end else if (ic_wrap) begin
      count_reg <= preset_reg;
    end else if (period_pulse) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // line tick source select
  always_comb begin
    case (ctrl_reg[CTRL_LT_SRC_LO +: 2])
      SRC_LINE:     lt_tick = line_pulse;
      SRC_EXT:      lt_tick = ext_pulse;
      SRC_INTERVAL: lt_tick = ic_wrap && ctrl_reg[CTRL_IC_TICK];
      default:      lt_tick = 1'b0;
    endcase
  end

  // one tick may wait while an increment is in flight
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      held_reg <= 1'b0;
    end else if (lt_tick && ctrl_reg[CTRL_LT_RUN]) begin
      held_reg <= 1'b1;
    end else if (mem_state_reg == CLKCTL_IDLE) begin
      held_reg <= 1'b0;
    end
  end

  // read-modify-write of the memory cell
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_state_reg <= CLKCTL_IDLE;
      mem_req       <= 1'b0;
      mem_we        <= 1'b0;
      mem_addr      <= 16'h0000;
      mem_wdata     <= 16'h0000;
    end else begin
      case (mem_state_reg)
        CLKCTL_IDLE: begin
          if (held_reg) begin
            mem_state_reg <= CLKCTL_READ;
            mem_req       <= 1'b1;
            mem_we        <= 1'b0;
            mem_addr      <= cell_reg;
          end
        end
        CLKCTL_READ: begin
          if (mem_done) begin
            mem_state_reg <= CLKCTL_WRITE;
            mem_we        <= 1'b1;
            mem_wdata     <= mem_rdata + 16'h0001;
          end
        end
        CLKCTL_WRITE: begin
          if (mem_done) begin
            mem_state_reg <= CLKCTL_IDLE;
            mem_req       <= 1'b0;
            mem_we        <= 1'b0;
          end
        end
        default: mem_state_reg <= CLKCTL_IDLE;
      endcase
    end
  end

  assign lt_wrap = (mem_state_reg == CLKCTL_WRITE) && mem_done && (mem_wdata == 16'h0000);

  // watchdog: write to its offset triggers or retriggers
  assign wd_trig   = reg_wr && (reg_addr == OFS_WDOG);
  // a retrigger in the last cycle restarts the span instead of timing out
  assign wd_expire = wd_run_reg && (wd_cnt_reg == WDW'(1)) && !wd_trig;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wd_cnt_reg <= '0;
      wd_run_reg <= 1'b0;
      wd_to_reg  <= 1'b0;
    end else if (wd_trig) begin
      wd_cnt_reg <= WDW'(WD_CYCLES);
      wd_run_reg <= 1'b1;
      wd_to_reg  <= 1'b0;
    end else if (wd_expire) begin
      wd_cnt_reg <= '0;
      wd_run_reg <= 1'b0;
      wd_to_reg  <= 1'b1;
    end else if (wd_run_reg) begin
      wd_cnt_reg <= wd_cnt_reg - WDW'(1);
    end
  end

  // sticky status, write one to clear, set wins
  assign events = {wd_expire & ctrl_reg[CTRL_WD_INT],
                   ic_wrap & ctrl_reg[CTRL_IC_IRQ],
                   lt_wrap};
  assign w1c = (reg_wr && reg_addr == OFS_STATUS) ? reg_wdata[ST_W-1:0] : '0;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~w1c) | events;
    end
  end

  // one interrupt at a time until acknowledged
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_reg     <= 1'b0;
      irq_vectored <= 1'b0;
      irq_vector   <= 16'h0000;
    end else if (pend_reg) begin
      if (reg_wr && reg_addr == OFS_ACK) begin
        pend_reg <= 1'b0;
      end
    end else if (|(status_reg & mask_reg)) begin
      pend_reg     <= 1'b1;
      irq_vectored <= ctrl_reg[CTRL_VECTORED] && !(status_reg[ST_WD_TO] && mask_reg[ST_WD_TO]);
      irq_vector   <= (status_reg[ST_WD_TO] && mask_reg[ST_WD_TO]) ? WDOG_INT_LOC : vector_reg;
    end
  end

  // outputs from flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq             <= 1'b0;
      wdog_int        <= 1'b0;
      sys_reset       <= 1'b0;
      timeout_conduct <= 1'b1;
    end else begin
      irq             <= pend_reg;
      wdog_int        <= wd_expire && ctrl_reg[CTRL_WD_INT];
      sys_reset       <= wd_expire && ctrl_reg[CTRL_WD_RST];
      timeout_conduct <= !(wd_to_reg || wd_expire);
    end
  end

  // read data one cycle later
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL:    rdata_reg <= {{(16-CTRL_W){1'b0}}, ctrl_reg};
        OFS_STATUS:  rdata_reg <= {{(16-ST_W){1'b0}}, status_reg};
        OFS_MASK:    rdata_reg <= {{(16-ST_W){1'b0}}, mask_reg};
        OFS_PRESET:  rdata_reg <= preset_reg;
        OFS_COUNT:   rdata_reg <= count_reg;
        OFS_CELLADR: rdata_reg <= cell_reg;
        OFS_VECTOR:  rdata_reg <= vector_reg;
        OFS_WDOG:    rdata_reg <= {14'h0000, wd_to_reg, wd_run_reg};
        OFS_PENDING: rdata_reg <= {15'h0000, pend_reg};
        default:     rdata_reg <= 16'h0000;
      endcase
    end else begin
      rdata_reg <= 16'h0000;
    end
  end
  assign reg_rdata = rdata_reg;

  // checks
  sequence s_wd_trigger;
    wd_trig;
  endsequence

  a_wd_quiet: assert property (@(posedge clk) disable iff (!rstn)
    s_wd_trigger |=> !wd_to_reg [*8])
    else $error("watchdog timed out too soon after trigger");
  a_wd_expiry: assert property (@(posedge clk) disable iff (!rstn)
    wd_expire |=> wd_to_reg && !wd_run_reg)
    else $error("watchdog expiry not latched");
  a_timeout_pin: assert property (@(posedge clk) disable iff (!rstn)
    wd_expire |=> !timeout_conduct)
    else $error("timeout output still conducting");
  a_ic_reload: assert property (@(posedge clk) disable iff (!rstn)
    (ic_wrap && !(reg_wr && reg_addr == OFS_PRESET)) |=> count_reg == $past(preset_reg))
    else $error("interval counter not reloaded");
  a_ic_step: assert property (@(posedge clk) disable iff (!rstn)
    (period_pulse && !ic_wrap && !(reg_wr && reg_addr == OFS_PRESET)) |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("interval counter missed a step");
  a_irq_hold: assert property (@(posedge clk) disable iff (!rstn)
    (pend_reg && !(reg_wr && reg_addr == OFS_ACK)) |=> pend_reg && $stable(irq_vector))
    else $error("pending interrupt changed before ack");
  a_tick_held: assert property (@(posedge clk) disable iff (!rstn)
    (held_reg && mem_state_reg != CLKCTL_IDLE) |=> held_reg)
    else $error("held tick dropped");
  a_mem_start: assert property (@(posedge clk) disable iff (!rstn)
    (held_reg && mem_state_reg == CLKCTL_IDLE) |=> mem_req && !mem_we && mem_addr == $past(cell_reg))
    else $error("increment read not started");
  a_wrap_flag: assert property (@(posedge clk) disable iff (!rstn)
    lt_wrap |=> status_reg[ST_LT_WRAP])
    else $error("cell wrap not flagged");
  a_wd_reset: assert property (@(posedge clk) disable iff (!rstn)
    (wd_expire && ctrl_reg[CTRL_WD_RST]) |=> sys_reset ##1 !sys_reset)
    else $error("system reset pulse wrong");
endmodule
`default_nettype wire

/* test/clkctl_mem_model.sv */
// Purpose: host memory that answers the controller's increment cycles
// Assumes: one access phase open at a time, same clock as the controller
// Notes:   answer delay set by the bench; data bus changes outside done
`timescale 1ns/1ns
`default_nettype none
module clkctl_mem_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // memory port
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic [15:0]      mem_rdata,
  output logic             mem_done,
  // answer delay in cycles
  input  wire logic [3:0]  delay
);
  logic [15:0] cells [16];
  logic [3:0]  wait_cnt;

  // data toggles when not valid, so a late sample never passes by luck
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_done  <= 1'b0;
      mem_rdata <= 16'h5a5a;
      wait_cnt  <= 4'h0;
    end else begin
      mem_done  <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_done) begin
        if (wait_cnt == delay) begin
          wait_cnt <= 4'h0;
          mem_done <= 1'b1;
          if (mem_we)
            cells[mem_addr[3:0]] <= mem_wdata;
          else
            mem_rdata <= cells[mem_addr[3:0]];
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* test/clkctl_top_tb.sv */
// Purpose: self-checking bench for the clock controller
// Assumes: shortened prescale and watchdog spans
// Notes:   host memory answered by clkctl_mem_model
`timescale 1ns/1ns
`default_nettype none
module clkctl_top_tb
  import clkctl_pkg::*;
();
  localparam int WD = 50;
  localparam int FA = 4;
  localparam int SL = 8;
  logic        clk, rstn, reg_wr, reg_rd, mem_req, mem_we, mem_done, irq, irq_vectored;
  logic        wdog_int, sys_reset, line_freq_in, ext_clk_in, timeout_conduct, seen_rst, seen_int;
  logic [3:0]  reg_addr, mem_delay;
  logic [15:0] reg_wdata, reg_rdata, mem_addr, mem_wdata, mem_rdata, irq_vector;
  int          error_cnt, n_checks;

  clkctl_top #(.WD_CYCLES(WD), .FAST(FA), .SLOW(SL)) dut (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_done(mem_done),
    .irq(irq), .irq_vectored(irq_vectored), .irq_vector(irq_vector), .wdog_int(wdog_int),
    .sys_reset(sys_reset), .line_freq_in(line_freq_in), .ext_clk_in(ext_clk_in),
    .timeout_conduct(timeout_conduct));
  clkctl_mem_model mem (
    .clk(clk), .rstn(rstn), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_done(mem_done), .delay(mem_delay));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (sys_reset === 1'b1) seen_rst <= 1'b1;
    if (wdog_int === 1'b1) seen_int <= 1'b1;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [15:0] inr(input int n, input int lo, input int hi);
    return (n >= lo && n <= hi) ? 16'h0001 : 16'h0000;
  endfunction
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] exp, input string what);
    logic [15:0] d;
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    chk(what, exp, d & m);
  endtask
  task automatic wait_irq(input int lim, output int n);
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  task automatic clr(input logic [15:0] m);
    wr(OFS_STATUS, m);
    wr(OFS_ACK, 16'h0000);
    repeat (3) @(posedge clk);
    #1 chk("irq after ack", 16'h0000, {15'h0, irq});
  endtask

  task automatic t_reset;
    chk("conduct at reset", 16'h0001, {15'h0, timeout_conduct});
    chk("irq at reset", 16'h0000, {15'h0, irq});
    rd(OFS_CTRL, 16'hffff, {6'h0, CTRL_RESET}, "ctrl reset");
    rd(OFS_VECTOR, 16'hffff, VECTOR_RESET, "vector reset");
    wr(4'hf, 16'hbeef);
    rd(4'hf, 16'hffff, 16'h0000, "unmapped read");
    wr(OFS_COUNT, 16'h1234);
    rd(OFS_COUNT, 16'hffff, 16'h0000, "counter read only");
  endtask

  task automatic t_interval;
    int n;
    wr(OFS_VECTOR, 16'h1234);
    wr(OFS_MASK, 16'h0002);
    wr(OFS_PRESET, 16'hfffd);
    rd(OFS_COUNT, 16'hffff, 16'hfffd, "preset loads counter");
    rd(OFS_PRESET, 16'hffff, 16'hfffd, "preset readback");
    wr(OFS_CTRL, 16'h0205);
    wait_irq(3 * FA + 20, n);
    chk("fast span", 16'h0001, inr(n, 3 * FA, 3 * FA + 6));
    chk("vectored", 16'h0001, {15'h0, irq_vectored});
    chk("vector", 16'h1234, irq_vector);
    wr(OFS_CTRL, 16'h0000);
    rd(OFS_STATUS, 16'h0002, 16'h0002, "interval wrap status");
    clr(16'h0007);
    wr(OFS_PRESET, 16'hffff);
    wr(OFS_CTRL, 16'h0207);
    wait_irq(SL + 20, n);
    chk("slow span one period", 16'h0001, inr(n, SL, SL + 6));
    wr(OFS_CTRL, 16'h0000);
    clr(16'h0007);
  endtask

  task automatic t_line(input logic [15:0] ctrl, input int src, input logic [3:0] dly);
    int n;
    mem_delay <= dly;
    mem.cells[5 + src] = 16'hfffe;
    wr(OFS_PRESET, 16'hffff);
    wr(OFS_CELLADR, 16'h0005 + 16'(src));
    wr(OFS_MASK, 16'h0001);
    wr(OFS_CTRL, ctrl);
    for (int i = 0; i < 2 && src < 2; i++) begin
      @(posedge clk);
      if (src == 0) line_freq_in <= 1'b1;
      else ext_clk_in <= 1'b1;
      repeat (4) @(posedge clk);
      line_freq_in <= 1'b0;
      ext_clk_in   <= 1'b0;
      repeat (20) @(posedge clk);
      #1 if (i == 0) chk("no irq before wrap", 16'h0000, {15'h0, irq});
    end
    wait_irq(60, n);
    wr(OFS_CTRL, 16'h0000);
    chk("cell wrapped", 16'h0000, mem.cells[5 + src]);
    chk("standard irq", 16'h0000, {15'h0, irq_vectored});
    rd(OFS_STATUS, 16'h0001, 16'h0001, "cell wrap status");
    clr(16'h0007);
  endtask

  task automatic t_wdog;
    int n;
    wr(OFS_MASK, 16'h0006);
    wr(OFS_CTRL, 16'h0385);
    wait_irq(FA + 20, n);
    // vectored mode stays on, so the fixed watchdog location must win
    wr(OFS_CTRL, 16'h0380);
    wr(OFS_WDOG, 16'h0000);
    // host retriggers inside every span
    repeat (3) begin
      repeat (40) @(posedge clk);
      #1 chk("conduct while fed", 16'h0001, {15'h0, timeout_conduct});
      wr(OFS_WDOG, 16'h0000);
    end
    chk("no early reset", 16'h0000, {15'h0, seen_rst});
    n = 0;
    while (timeout_conduct !== 1'b0 && n < WD + 20) begin
      @(posedge clk);
      #1 n++;
    end
    chk("timeout span", 16'h0001, inr(n, WD, WD + 4));
    repeat (3) @(posedge clk);
    chk("reset pulse", 16'h0001, {15'h0, seen_rst});
    chk("internal int", 16'h0001, {15'h0, seen_int});
    chk("held off vector", 16'h1234, irq_vector);
    rd(OFS_PENDING, 16'h0001, 16'h0001, "pending flag");
    rd(OFS_WDOG, 16'h0002, 16'h0002, "timed out flag");
    // the watchdog status stays set, so a new interrupt follows the ack
    wr(OFS_STATUS, 16'h0002);
    wr(OFS_ACK, 16'h0000);
    @(posedge clk);
    #1 chk("irq drops on ack", 16'h0000, {15'h0, irq});
    wait_irq(10, n);
    chk("watchdog vector", WDOG_INT_LOC, irq_vector);
    chk("watchdog not vectored", 16'h0000, {15'h0, irq_vectored});
    wr(OFS_WDOG, 16'h0000);
    repeat (2) @(posedge clk);
    #1 chk("conduct after retrigger", 16'h0001, {15'h0, timeout_conduct});
    clr(16'h0007);
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #400_000;
    error_cnt++;
    print_verdict;
  end

  initial begin
    rstn = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    line_freq_in = 1'b0;
    ext_clk_in = 1'b0;
    mem_delay = 4'h0;
    seen_rst = 1'b0;
    seen_int = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_interval;
    t_line(16'h0040, 0, 4'h0);
    t_line(16'h0050, 1, 4'h3);
    t_line(16'h006b, 2, 4'h1);
    t_wdog;
    print_verdict;
  end
endmodule
`default_nettype wire
